//--- logic/flash_rewrite_status_control.sv
// flash rewrite status and control registers behind an ahb-lite slave
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps

// How it works
// - access to the busy block with access-error enable sets access-error request
// - command, erase, blank or program error with command-error enable sets it too
// - data-flash read during program-area rewrite with access-error enable also sets access-error request
// - access-error request clears on software write of 0 or clear-status command
// - lock monitor is read-only, captured on return to ready after a command
// - program error flag reads 1 after a failed program or a command sequence error, else 0
// - erase error flag reads 1 after failed erase, blank check or command sequence error, else 0
// - suspend flag reads 1 only while the erase is suspended
// - ready/busy reads 0 during any operation, reset, stop or wake, else 1
// - control resets to zero; bits 1..7 rewrite, mode, stop, reset, three enables
// - flash stop acts only with rewrite enabled; software sets it only when ready (the register stores the bit on any write)
// - sequence reset acts only when rewrite enabled and busy; always reads 0
// - commands are accepted only while rewrite mode is enabled
// - flash stop initialises control, enters low power and blocks accesses
// - sequence reset aborts program or erase and also drops a suspended erase
// - after the reset-to-ready delay the command stops and reads are allowed
// - command-error enable raises a command error interrupt on any command error
// - busy-to-ready with ready enable sets ready request; software cannot set it
module flash_rewrite_status_control (
    // system
    input wire logic CLK,
    input wire logic RESET,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    // only whole words are transferred, so the size is not decoded
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // flash array sequencer
    input wire flash_ctl_pkg::core_status_t CORE_STATUS,
    output flash_ctl_pkg::core_ctrl_t CORE_CTRL,
    // interrupt requests
    output logic IRQ_READY,
    output logic IRQ_ACCESS_ERROR,
    output logic IRQ_COMMAND_ERROR
);
    import flash_ctl_pkg::*;

    // control register
    logic rewrite_enable_ff;
    logic second_mode_select_ff;
    logic flash_stop_ff;
    logic command_error_int_enable_ff;
    logic access_error_int_enable_ff;
    logic ready_status_int_enable_ff;

    // status register
    logic ready_status_request_ff;
    logic access_error_request_ff;
    logic lock_status_monitor_ff;
    logic program_error_flag_ff;
    logic erase_error_flag_ff;
    logic suspend_status_flag_ff;
    logic ready_busy_flag_ff;

    // internal sequencing
    seq_state_t seq_state_ff;
    seq_state_t nxt_seq_state;
    logic [CNT_W-1:0] seq_count_ff;
    logic [CNT_W-1:0] nxt_seq_count;
    logic stop_active_ff;
    logic lock_pending_ff;

    // bus data phase
    logic wr_pend_ff;
    logic wr_ctl_ff;
    logic wr_sts_ff;

    logic addr_phase;
    logic [7:0] wdata;
    logic ctl_wr;
    logic sts_wr;
    logic stop_eff;
    logic seq_busy;
    logic busy_now;
    logic stop_change;
    logic ready_rise;
    logic seq_reset_go;
    logic cmd_error_evt;
    logic access_set;
    logic access_clr;
    logic ready_set;
    logic ready_clr;
    logic [7:0] sts_rd;
    logic [7:0] ctl_rd;

    assign addr_phase = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);
    assign wdata = HWDATA[7:0];
    assign ctl_wr = wr_pend_ff & wr_ctl_ff;
    assign sts_wr = wr_pend_ff & wr_sts_ff;

    assign stop_eff = flash_stop_ff & rewrite_enable_ff;
    assign seq_busy = (seq_state_ff != SEQ_IDLE);
    // a stop or wake write shows busy from its own data edge, so the very next
    // status read cannot catch a stale ready before the settle window starts
    assign stop_change = (stop_eff != stop_active_ff)
                         | (ctl_wr & (stop_eff
                            != (wdata[CTL_STOP_BIT] & wdata[CTL_REWRITE_BIT])));
    assign busy_now = CORE_STATUS.busy | seq_busy | stop_change;
    assign ready_rise = ~ready_busy_flag_ff & ~busy_now;
    // judged against the flag software last saw, so a reset on a ready flash is dropped
    assign seq_reset_go = ctl_wr & wdata[CTL_SEQ_RESET_BIT] & rewrite_enable_ff
                          & ~ready_busy_flag_ff;

    assign cmd_error_evt = CORE_STATUS.program_fail | CORE_STATUS.erase_fail
                           | CORE_STATUS.blank_fail | CORE_STATUS.sequence_error;
    assign access_set = (access_error_int_enable_ff & CORE_STATUS.busy_block_access)
                        | (access_error_int_enable_ff
                           & CORE_STATUS.data_read_in_rom_rewrite)
                        | (command_error_int_enable_ff & cmd_error_evt);
    assign access_clr = (sts_wr & ~wdata[STS_ACCESS_ERR_BIT])
                        | CORE_STATUS.clear_status;
    assign ready_set = ready_rise & ready_status_int_enable_ff;
    assign ready_clr = sts_wr & ~wdata[STS_READY_REQ_BIT];

    // ahb-lite: zero wait states, read data registered at the address phase
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_pend_ff <= 1'b0;
            wr_ctl_ff <= 1'b0;
            wr_sts_ff <= 1'b0;
        end else begin
            wr_pend_ff <= addr_phase & HWRITE;
            wr_ctl_ff <= (HADDR == FLASH_CONTROL_ZERO_ADDR);
            wr_sts_ff <= (HADDR == FLASH_STATUS_ADDR);
        end
    end

    always_comb begin
        sts_rd = BYTE_ZERO;
        sts_rd[STS_READY_REQ_BIT] = ready_status_request_ff;
        sts_rd[STS_ACCESS_ERR_BIT] = access_error_request_ff;
        sts_rd[STS_LOCK_BIT] = lock_status_monitor_ff;
        sts_rd[STS_PROG_ERR_BIT] = program_error_flag_ff;
        sts_rd[STS_ERASE_ERR_BIT] = erase_error_flag_ff;
        sts_rd[STS_SUSPEND_BIT] = suspend_status_flag_ff;
        sts_rd[STS_READY_BUSY_BIT] = ready_busy_flag_ff;
        ctl_rd = BYTE_ZERO;
        ctl_rd[CTL_REWRITE_BIT] = rewrite_enable_ff;
        ctl_rd[CTL_SECOND_MODE_BIT] = second_mode_select_ff;
        ctl_rd[CTL_STOP_BIT] = flash_stop_ff;
        ctl_rd[CTL_CMD_ERR_IE_BIT] = command_error_int_enable_ff;
        ctl_rd[CTL_ACCESS_ERR_IE_BIT] = access_error_int_enable_ff;
        ctl_rd[CTL_READY_IE_BIT] = ready_status_int_enable_ff;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            HRDATA <= {UPPER_ZERO, BYTE_ZERO};
            HREADYOUT <= 1'b1;
            HRESP <= HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= HRESP_OKAY;
            if (addr_phase & ~HWRITE) begin
                if (HADDR == FLASH_STATUS_ADDR) begin
                    HRDATA <= {UPPER_ZERO, sts_rd};
                end else if (HADDR == FLASH_CONTROL_ZERO_ADDR) begin
                    HRDATA <= {UPPER_ZERO, ctl_rd};
                end else begin
                    HRDATA <= {UPPER_ZERO, BYTE_ZERO};
                end
            end
        end
    end

    // control register; the 0-then-1 write pair is the software's job
    // reserved bit 0 and the self-clearing sequence-reset bit are never stored
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rewrite_enable_ff <= CTL_BIT_RESET;
            second_mode_select_ff <= CTL_BIT_RESET;
            flash_stop_ff <= CTL_BIT_RESET;
            command_error_int_enable_ff <= CTL_BIT_RESET;
            access_error_int_enable_ff <= CTL_BIT_RESET;
            ready_status_int_enable_ff <= CTL_BIT_RESET;
        end else if (ctl_wr) begin
            rewrite_enable_ff <= wdata[CTL_REWRITE_BIT];
            second_mode_select_ff <= wdata[CTL_SECOND_MODE_BIT];
            flash_stop_ff <= wdata[CTL_STOP_BIT];
            command_error_int_enable_ff <= wdata[CTL_CMD_ERR_IE_BIT];
            access_error_int_enable_ff <= wdata[CTL_ACCESS_ERR_IE_BIT];
            ready_status_int_enable_ff <= wdata[CTL_READY_IE_BIT];
        end
    end

    // busy windows owned by this block: forced stop and stop/wake settling
    always_comb begin
        nxt_seq_state = seq_state_ff;
        nxt_seq_count = seq_count_ff;
        // a forced stop written during a settle window restarts the count
        if (seq_reset_go) begin
            nxt_seq_state = SEQ_RESETTING;
            nxt_seq_count = RESET_TO_READY_LOAD;
        end else begin
            case (seq_state_ff)
                SEQ_IDLE: begin
                    if (stop_eff != stop_active_ff) begin
                        nxt_seq_state = SEQ_SETTLING;
                        nxt_seq_count = STOP_SETTLE_LOAD;
                    end
                end
                SEQ_RESETTING, SEQ_SETTLING: begin
                    if (seq_count_ff == CNT_ZERO) begin
                        nxt_seq_state = SEQ_IDLE;
                    end else begin
                        nxt_seq_count = seq_count_ff - 1'b1;
                    end
                end
                default: begin
                    nxt_seq_state = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            seq_state_ff <= SEQ_IDLE;
            seq_count_ff <= CNT_ZERO;
            stop_active_ff <= 1'b0;
        end else begin
            seq_state_ff <= nxt_seq_state;
            seq_count_ff <= nxt_seq_count;
            stop_active_ff <= stop_eff;
        end
    end

    // status flags; in every set/clear pair the set wins
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ready_busy_flag_ff <= READY_BUSY_RESET;
            ready_status_request_ff <= FLAG_RESET;
            access_error_request_ff <= FLAG_RESET;
        end else begin
            ready_busy_flag_ff <= ~busy_now;
            if (ready_set) begin
                ready_status_request_ff <= 1'b1;
            end else if (ready_clr) begin
                ready_status_request_ff <= 1'b0;
            end
            if (access_set) begin
                access_error_request_ff <= 1'b1;
            end else if (access_clr) begin
                access_error_request_ff <= 1'b0;
            end
        end
    end

    // error flags hold until a clear-status command
    always_ff @(posedge CLK) begin
        if (RESET) begin
            program_error_flag_ff <= FLAG_RESET;
            erase_error_flag_ff <= FLAG_RESET;
        end else begin
            if (CORE_STATUS.program_fail | CORE_STATUS.sequence_error) begin
                program_error_flag_ff <= 1'b1;
            end else if (CORE_STATUS.clear_status) begin
                program_error_flag_ff <= 1'b0;
            end
            if (CORE_STATUS.erase_fail | CORE_STATUS.blank_fail
                | CORE_STATUS.sequence_error) begin
                erase_error_flag_ff <= 1'b1;
            end else if (CORE_STATUS.clear_status) begin
                erase_error_flag_ff <= 1'b0;
            end
        end
    end

    // a sequence reset drops the suspended erase even before the core reacts
    always_ff @(posedge CLK) begin
        if (RESET) begin
            suspend_status_flag_ff <= FLAG_RESET;
        end else begin
            suspend_status_flag_ff <= CORE_STATUS.suspended & ~seq_reset_go
                                      & (seq_state_ff != SEQ_RESETTING);
        end
    end

    // lock monitor only changes on the ready edge that ends a command
    // resets to not-locked; the first completed command replaces it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            lock_status_monitor_ff <= LOCK_MONITOR_RESET;
            lock_pending_ff <= 1'b0;
        end else begin
            if (CORE_STATUS.cmd_start) begin
                lock_pending_ff <= 1'b1;
            end else if (ready_rise) begin
                lock_pending_ff <= 1'b0;
            end
            if (ready_rise & lock_pending_ff) begin
                lock_status_monitor_ff <= CORE_STATUS.lock_status;
            end
        end
    end

    // controls to the array sequencer
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CORE_CTRL <= '0;
        end else begin
            CORE_CTRL.command_accept <= rewrite_enable_ff & ~stop_eff;
            CORE_CTRL.second_mode <= second_mode_select_ff;
            CORE_CTRL.stop <= stop_eff;
            CORE_CTRL.init <= stop_eff & ~stop_active_ff;
            CORE_CTRL.abort <= seq_reset_go;
        end
    end

    // interrupt levels, one cycle behind the flags
    // the command error line shares the access-error request, so one clear drops both
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ_READY <= 1'b0;
            IRQ_ACCESS_ERROR <= 1'b0;
            IRQ_COMMAND_ERROR <= 1'b0;
        end else begin
            IRQ_READY <= ready_status_request_ff & ready_status_int_enable_ff;
            IRQ_ACCESS_ERROR <= access_error_request_ff & access_error_int_enable_ff;
            IRQ_COMMAND_ERROR <= access_error_request_ff
                                 & command_error_int_enable_ff;
        end
    end

endmodule : flash_rewrite_status_control

//--- logic/flash_ctl_pkg.sv
// constants, register map and carrier types for the flash rewrite status/control block
package flash_ctl_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_TO_READY_DELAY_NS = 1000;
    localparam int STOP_SETTLE_NS = 500;
    // both are least times, so round up to whole cycles
    localparam int RESET_TO_READY_CYCLES =
        (RESET_TO_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_SETTLE_CYCLES = (STOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] RESET_TO_READY_LOAD = CNT_W'(RESET_TO_READY_CYCLES - 1);
    localparam logic [CNT_W-1:0] STOP_SETTLE_LOAD = CNT_W'(STOP_SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // register indices; byte address is four times the index
    localparam logic [15:0] FLASH_STATUS_IDX = 16'h01b2;
    localparam logic [15:0] FLASH_CONTROL_ZERO_IDX = 16'h01b4;
    localparam logic [31:0] FLASH_STATUS_ADDR = {14'h0000, FLASH_STATUS_IDX, 2'h0};
    localparam logic [31:0] FLASH_CONTROL_ZERO_ADDR = {14'h0000, FLASH_CONTROL_ZERO_IDX, 2'h0};

    // flash_status bit positions
    localparam int STS_READY_REQ_BIT = 0;
    localparam int STS_ACCESS_ERR_BIT = 1;
    localparam int STS_LOCK_BIT = 2;
    localparam int STS_PROG_ERR_BIT = 4;
    localparam int STS_ERASE_ERR_BIT = 5;
    localparam int STS_SUSPEND_BIT = 6;
    localparam int STS_READY_BUSY_BIT = 7;

    // flash_control_zero bit positions
    localparam int CTL_REWRITE_BIT = 1;
    localparam int CTL_SECOND_MODE_BIT = 2;
    localparam int CTL_STOP_BIT = 3;
    localparam int CTL_SEQ_RESET_BIT = 4;
    localparam int CTL_CMD_ERR_IE_BIT = 5;
    localparam int CTL_ACCESS_ERR_IE_BIT = 6;
    localparam int CTL_READY_IE_BIT = 7;

    // reset values
    localparam logic CTL_BIT_RESET = 1'b0;
    localparam logic READY_BUSY_RESET = 1'b1;
    localparam logic LOCK_MONITOR_RESET = 1'b1;
    localparam logic FLAG_RESET = 1'b0;

    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [23:0] UPPER_ZERO = 24'h000000;

    typedef enum {SEQ_IDLE, SEQ_RESETTING, SEQ_SETTLING} seq_state_t;

    // events and levels reported by the flash array sequencer
    typedef struct packed {
        logic busy;
        logic suspended;
        logic lock_status;
        logic cmd_start;
        logic clear_status;
        logic program_fail;
        logic erase_fail;
        logic blank_fail;
        logic sequence_error;
        logic busy_block_access;
        logic data_read_in_rom_rewrite;
    } core_status_t;

    // controls handed to the flash array sequencer
    typedef struct packed {
        logic command_accept;
        logic second_mode;
        logic stop;
        logic init;
        logic abort;
    } core_ctrl_t;

endpackage : flash_ctl_pkg

//--- dv/flash_rewrite_monitor.sv
// checker for the flash rewrite status/control block ports
`timescale 1ns/10ps
module flash_rewrite_monitor (
    // system
    input wire logic CLK,
    input wire logic RESET,
    // bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    // core and interrupts
    input wire flash_ctl_pkg::core_status_t CORE_STATUS,
    input wire flash_ctl_pkg::core_ctrl_t CORE_CTRL,
    input wire logic IRQ_READY,
    input wire logic IRQ_ACCESS_ERROR,
    input wire logic IRQ_COMMAND_ERROR
);
    import flash_ctl_pkg::*;

    logic wr_ctl_ff;
    logic req_ff;
    logic [7:0] ctl_ff;

    // shadow of the control byte, so the enables are judged from the bus alone
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_ctl_ff <= 1'b0;
            req_ff <= 1'b0;
            ctl_ff <= BYTE_ZERO;
        end else begin
            wr_ctl_ff <= HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE
                && HADDR == FLASH_CONTROL_ZERO_ADDR;
            req_ff <= wr_ctl_ff && HWDATA[CTL_SEQ_RESET_BIT] && ctl_ff[CTL_REWRITE_BIT];
            if (wr_ctl_ff) begin
                ctl_ff <= HWDATA[7:0];
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence cmd_fail_s;
        CORE_STATUS.program_fail || CORE_STATUS.erase_fail || CORE_STATUS.blank_fail
            || CORE_STATUS.sequence_error;
    endsequence
    sequence abort_s;
        req_ff ##0 CORE_CTRL.abort;
    endsequence

    access_err_set_a: assert property (CORE_STATUS.busy_block_access
        && ctl_ff[CTL_ACCESS_ERR_IE_BIT] |-> ##2 IRQ_ACCESS_ERROR)
        else $error("access error request not raised");
    rom_read_err_a: assert property (CORE_STATUS.data_read_in_rom_rewrite
        && ctl_ff[CTL_ACCESS_ERR_IE_BIT] |-> ##2 IRQ_ACCESS_ERROR)
        else $error("data read during rom rewrite not flagged");
    cmd_err_set_a: assert property (cmd_fail_s ##0 ctl_ff[CTL_CMD_ERR_IE_BIT]
        |-> ##2 IRQ_COMMAND_ERROR)
        else $error("command error interrupt missing");
    ready_irq_a: assert property ($fell(CORE_STATUS.busy) && ctl_ff[CTL_READY_IE_BIT]
        |-> ##[2:4] IRQ_READY)
        else $error("ready request not raised");
    irq_masked_a: assert property ((!ctl_ff[CTL_READY_IE_BIT] |=> !IRQ_READY)
        and (!ctl_ff[CTL_ACCESS_ERR_IE_BIT] |=> !IRQ_ACCESS_ERROR)
        and (!ctl_ff[CTL_CMD_ERR_IE_BIT] |=> !IRQ_COMMAND_ERROR))
        else $error("interrupt raised while disabled");
    abort_cause_a: assert property (CORE_CTRL.abort |-> req_ff)
        else $error("abort without an accepted sequence reset");
    abort_once_a: assert property (abort_s |=> !CORE_CTRL.abort)
        else $error("abort longer than one cycle");
    accept_gate_a: assert property (CORE_CTRL.command_accept
        |-> ctl_ff[CTL_REWRITE_BIT] || $past(ctl_ff[CTL_REWRITE_BIT]))
        else $error("commands accepted with rewrite disabled");
    stop_gate_a: assert property ($rose(CORE_CTRL.stop)
        |-> $past(ctl_ff[CTL_STOP_BIT] && ctl_ff[CTL_REWRITE_BIT]))
        else $error("flash stop without rewrite enabled");
    stop_init_a: assert property ($rose(CORE_CTRL.stop)
        |-> CORE_CTRL.init ##1 !CORE_CTRL.init)
        else $error("flash stop without a single init pulse");
    reset_quiet_a: assert property ($past(RESET) |-> CORE_CTRL == 5'h00 && !IRQ_READY
        && !IRQ_ACCESS_ERROR && !IRQ_COMMAND_ERROR)
        else $error("outputs not quiet after reset");
endmodule : flash_rewrite_monitor

//--- dv/flash_rewrite_status_control_bench.sv
// self-checking bench for the flash rewrite status/control block
`timescale 1ns/10ps
module flash_rewrite_status_control_bench;
    import flash_ctl_pkg::*;
    localparam logic [31:0] ST = FLASH_STATUS_ADDR;
    localparam logic [31:0] CT = FLASH_CONTROL_ZERO_ADDR;
    localparam int CMD_START = 7;
    localparam int CLR = 6;
    localparam int BUSY_ACC = 1;
    localparam int ROM_RD = 0;
    localparam int FAIL_IDX[4] = '{5, 4, 3, 2};
    localparam logic [7:0] FAIL_EXP[4] = '{8'h96, 8'ha6, 8'ha6, 8'hb6};
    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic irq_rdy, irq_acc, irq_cmd;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] v;
    core_status_t cs;
    core_ctrl_t cc;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 32'hc62f;
    string nm_q[$];
    logic [31:0] ex_q[$];

    assign hready = hreadyout;

    flash_rewrite_status_control i_dut (
        .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .CORE_STATUS(cs), .CORE_CTRL(cc),
        .IRQ_READY(irq_rdy), .IRQ_ACCESS_ERROR(irq_acc), .IRQ_COMMAND_ERROR(irq_cmd)
    );

    initial begin
        clk = 1'b0;
        forever begin
            #5 clk = ~clk;
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic check1(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask : check1

    task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {UPPER_ZERO, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] e, input string nm);
        nm_q.push_back(nm);
        ex_q.push_back({UPPER_ZERO, e});
        bus(1'b0, a, BYTE_ZERO);
    endtask : rd

    task automatic pulse(input int i);
        cs[i] <= 1'b1;
        @(posedge clk);
        cs[i] <= 1'b0;
        @(posedge clk);
    endtask : pulse

    // registered levels may lag their cause by a cycle, so look a little later
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // read data stands through the data phase; compare it mid-cycle
    always @(posedge clk) begin
        if (hsel && htrans == HTRANS_NONSEQ && !hwrite && !reset) begin
            @(negedge clk);
            check(nm_q.pop_front(), hrdata, ex_q.pop_front());
            check1("okay", hresp, HRESP_OKAY);
        end
    end

    // the whole sequence needs well under 1500 cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude;
    end

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        cs = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(ST, 8'h84, "status reset");
        rd(CT, 8'h00, "control reset");
        rd(CT + 32'h4, 8'h00, "unmapped");
        check1("accept off", cc.command_accept, 1'b0);
        wr(CT, 8'h00);
        wr(CT, 8'h02);
        rd(CT, 8'h02, "rewrite on");
        wr(CT, 8'h06);
        settle;
        check1("accept on", cc.command_accept, 1'b1);
        check1("second mode", cc.second_mode, 1'b1);
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            v = 8'($random(seed)) & 8'hf5 | 8'h02;
            wr(CT, v);
            rd(CT, v & 8'he6, "control rw");
        end
        rd(ST, 8'h84, "dummy read");
        wr(ST, 8'h00);
        wr(CT, 8'h42);
        cs.busy <= 1'b1;
        @(posedge clk);
        pulse(BUSY_ACC);
        rd(ST, 8'h06, "access err");
        settle;
        check1("access irq", irq_acc, 1'b1);
        check1("cmd irq idle", irq_cmd, 1'b0);
        @(posedge clk);
        wr(ST, 8'h03);
        rd(ST, 8'h06, "no sw set");
        wr(ST, 8'h00);
        rd(ST, 8'h04, "sw clear");
        pulse(ROM_RD);
        rd(ST, 8'h06, "rom read err");
        pulse(CLR);
        rd(ST, 8'h04, "clear cmd");
        wr(CT, 8'h02);
        pulse(BUSY_ACC);
        rd(ST, 8'h04, "access masked");
        pulse(CLR);
        cs.busy <= 1'b0;
        wr(CT, 8'h22);
        for (int k = 0; k < 4; k++) begin
            pulse(FAIL_IDX[k]);
            rd(ST, FAIL_EXP[k], "error flags");
            settle;
            check1("cmd err irq", irq_cmd, 1'b1);
            @(posedge clk);
            pulse(CLR);
            rd(ST, 8'h84, "errors cleared");
        end
        wr(ST, 8'h00);
        wr(CT, 8'h82);
        cs.busy <= 1'b1;
        cs.lock_status <= 1'b0;
        cs.suspended <= 1'b1;
        @(posedge clk);
        pulse(CMD_START);
        rd(ST, 8'h44, "busy suspended");
        cs.busy <= 1'b0;
        repeat (5) @(posedge clk);
        rd(ST, 8'hc1, "ready rise");
        settle;
        check1("ready irq", irq_rdy, 1'b1);
        @(posedge clk);
        cs.suspended <= 1'b0;
        wr(ST, 8'h00);
        rd(ST, 8'h80, "ready req clear");
        wr(CT, 8'h02);
        cs.busy <= 1'b1;
        repeat (2) @(posedge clk);
        wr(CT, 8'h12);
        @(negedge clk);
        check1("abort", cc.abort, 1'b1);
        @(posedge clk);
        cs.busy <= 1'b0;
        repeat (40) @(posedge clk);
        rd(ST, 8'h00, "reset window");
        repeat (80) @(posedge clk);
        rd(ST, 8'h80, "reset done");
        pulse(CLR);
        rd(CT, 8'h02, "reset bit reads 0");
        wr(CT, 8'h12);
        @(negedge clk);
        check1("no abort when ready", cc.abort, 1'b0);
        @(posedge clk);
        wr(CT, 8'h08);
        settle;
        check1("stop gated", cc.stop, 1'b0);
        @(posedge clk);
        wr(CT, 8'h0a);
        rd(ST, 8'h00, "stopping");
        settle;
        check1("stop", cc.stop, 1'b1);
        check1("accept blocked", cc.command_accept, 1'b0);
        repeat (60) @(posedge clk);
        rd(ST, 8'h80, "stopped ready");
        wr(CT, 8'h02);
        rd(ST, 8'h00, "waking");
        repeat (60) @(posedge clk);
        rd(ST, 8'h80, "awake");
        wr(ST, 8'h00);
        pulse(CLR);
        wr(CT, 8'he2);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(CT, 8'h00, "control after reset");
        rd(ST, 8'h84, "status after reset");
        conclude;
    end
endmodule : flash_rewrite_status_control_bench

bind flash_rewrite_status_control flash_rewrite_monitor i_mon (
    .CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
    .CORE_STATUS, .CORE_CTRL, .IRQ_READY, .IRQ_ACCESS_ERROR, .IRQ_COMMAND_ERROR
);
